// ---- logic/lrm_pkg.sv ----
// constants, field layouts and register map for the lcd row-mapping block
// assumes an apb master on mclk; one 32-bit word per register
// Behaviour
// - icon rows ignore the scroll start row
// - start row shown on first scrolling line
// - largest fixed-area setting fixes 24 rows
// - memory row index wraps after 128
// - tall display only while tall_enable set
// - tall area starts at first_row
// - tall area ends at last_row
// - odd tall span still reaches last_row
// - tall area fixed on screen during scroll
// - reverse bit inverts every displayed pixel
// - partial mode drives 16 rows, top or centre
// - undriven lines held at unselected level
// - duty code 1110 is 1/120, 0001 is 1/16
// - bias code 000 is 1/11, 110 is 1/5
// - boost code 10 six times, 00 two times
// - contrast field adjusts drive voltage finely
package lrm_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] LRM_ADDR_CTRL = 8'h00;
    localparam logic [7:0] LRM_ADDR_SCROLL = 8'h04;
    localparam logic [7:0] LRM_ADDR_TALL = 8'h08;
    localparam logic [7:0] LRM_ADDR_DRIVE = 8'h0C;
    localparam logic [7:0] LRM_ADDR_STATUS = 8'h10;
    // ==========================================
    // field positions
    localparam int LRM_CTRL_TALL_BIT = 0;
    localparam int LRM_CTRL_REV_BIT = 1;
    localparam int LRM_CTRL_PART_BIT = 2;
    localparam int LRM_CTRL_CENTRE_BIT = 3;
    localparam int LRM_SCROLL_FIX_LSB = 8;
    localparam int LRM_TALL_LAST_LSB = 8;
    localparam int LRM_DRIVE_BIAS_LSB = 4;
    localparam int LRM_DRIVE_BOOST_LSB = 8;
    localparam int LRM_DRIVE_CONTRAST_LSB = 12;
    // ==========================================
    // display geometry
    localparam logic [6:0] LRM_ROWS_LAST = 7'h7F;
    localparam logic [6:0] LRM_PART_ROWS = 7'h10;
    localparam logic [6:0] LRM_FIX_STEP = 7'h08;
    localparam logic [6:0] LRM_CENTRE_OFFSET = 7'h34;
    // ==========================================
    // drive decodes
    localparam logic [3:0] LRM_DUTY_120 = 4'hE;
    localparam logic [3:0] LRM_DUTY_16 = 4'h1;
    localparam logic [2:0] LRM_BIAS_11 = 3'h0;
    localparam logic [2:0] LRM_BIAS_5 = 3'h6;
    localparam logic [1:0] LRM_BOOST_6X = 2'h2;
    localparam logic [1:0] LRM_BOOST_2X = 2'h0;
    localparam logic [7:0] LRM_DIV_120 = 8'h78;
    localparam logic [7:0] LRM_DIV_16 = 8'h10;
    localparam logic [3:0] LRM_BIAS_DIV_11 = 4'hB;
    localparam logic [3:0] LRM_BIAS_DIV_5 = 4'h5;
    localparam logic [2:0] LRM_MULT_6 = 3'h6;
    localparam logic [2:0] LRM_MULT_2 = 3'h2;
    // ==========================================
    // reset values
    localparam logic [3:0] LRM_RST_DUTY = 4'hE;
    localparam logic [2:0] LRM_RST_BIAS = 3'h0;
    localparam logic [1:0] LRM_RST_BOOST = 2'h2;

    typedef struct packed {
        logic [6:0] mem_row;
        logic selected;
        logic reverse;
    } lrm_line_t;

    typedef struct packed {
        logic [7:0] duty_div;
        logic [3:0] bias_div;
        logic [2:0] boost_mult;
        logic [5:0] contrast;
    } lrm_drive_t;
endpackage

// ---- logic/lrm_row_map.sv ----
// row mapper: walks common lines, maps each to a memory raster-row
// assumes apb master on mclk; mclk stands in for the display clock
`timescale 1ns/1ps
module lrm_row_map
#(
    parameter int LINE_CYCLES = 4
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output lrm_pkg::lrm_line_t line_out,
    output logic [6:0] com_index,
    output lrm_pkg::lrm_drive_t drive_out
);
    import lrm_pkg::*;

    // ==========================================
    // registers
    logic tall_enable;
    logic reverse;
    logic partial_on;
    logic centre_shift;
    logic [6:0] scroll_start_row;
    logic [1:0] fixed_area_select;
    logic [6:0] tall_first_row;
    logic [6:0] tall_last_row;
    logic [3:0] duty_select;
    logic [2:0] bias_select;
    logic [1:0] boost_factor;
    logic [5:0] contrast_level;
    logic [6:0] com_line;
    logic [7:0] line_timer;

    logic access;
    assign access = psel && penable;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            tall_enable <= 1'b0;
            reverse <= 1'b0;
            partial_on <= 1'b0;
            centre_shift <= 1'b0;
            scroll_start_row <= '0;
            fixed_area_select <= '0;
            tall_first_row <= '0;
            tall_last_row <= '0;
            duty_select <= LRM_RST_DUTY;
            bias_select <= LRM_RST_BIAS;
            boost_factor <= LRM_RST_BOOST;
            contrast_level <= '0;
        end
        else if (access && pwrite)
        begin
            case (paddr)
                LRM_ADDR_CTRL:
                begin
                    tall_enable <= pwdata[LRM_CTRL_TALL_BIT];
                    reverse <= pwdata[LRM_CTRL_REV_BIT];
                    partial_on <= pwdata[LRM_CTRL_PART_BIT];
                    centre_shift <= pwdata[LRM_CTRL_CENTRE_BIT];
                end
                LRM_ADDR_SCROLL:
                begin
                    scroll_start_row <= pwdata[6:0];
                    fixed_area_select <= pwdata[LRM_SCROLL_FIX_LSB +: 2];
                end
                LRM_ADDR_TALL:
                begin
                    tall_first_row <= pwdata[6:0];
                    tall_last_row <= pwdata[LRM_TALL_LAST_LSB +: 7];
                end
                LRM_ADDR_DRIVE:
                begin
                    duty_select <= pwdata[3:0];
                    bias_select <= pwdata[LRM_DRIVE_BIAS_LSB +: 3];
                    boost_factor <= pwdata[LRM_DRIVE_BOOST_LSB +: 2];
                    contrast_level <= pwdata[LRM_DRIVE_CONTRAST_LSB +: 6];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================
    // apb answer: zero wait, error on unmapped address
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable)
            begin
                case (paddr)
                    LRM_ADDR_CTRL:
                        prdata <= {28'h0000000, centre_shift, partial_on, reverse, tall_enable};
                    LRM_ADDR_SCROLL:
                        prdata <= {22'h000000, fixed_area_select, 1'b0, scroll_start_row};
                    LRM_ADDR_TALL:
                        prdata <= {17'h00000, tall_last_row, 1'b0, tall_first_row};
                    LRM_ADDR_DRIVE:
                        prdata <= {14'h0000, contrast_level, 2'h0, boost_factor, 1'b0,
                            bias_select, duty_select};
                    LRM_ADDR_STATUS:
                        prdata <= {25'h0000000, com_line};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ==========================================
    // mapping functions
    function automatic logic [6:0] fixed_rows(input logic [1:0] sel);
        fixed_rows = 7'(sel * LRM_FIX_STEP);
    endfunction

    // double-height window in screen coordinates, unaffected by scroll
    function automatic logic in_tall(input logic [6:0] line, input logic [6:0] first,
        input logic [6:0] last);
        in_tall = (line >= first) && (line <= last);
    endfunction

    // ==========================================
    // line scan
    logic [6:0] window_lo;
    logic [6:0] window_hi;
    logic [6:0] fix_rows;
    logic [6:0] screen_row;
    logic [6:0] next_mem_row;
    logic next_selected;
    logic [6:0] tall_offset;

    always_comb
    begin
        fix_rows = fixed_rows(fixed_area_select);
        window_lo = centre_shift ? LRM_CENTRE_OFFSET : 7'h00;
        window_hi = 7'(window_lo + LRM_PART_ROWS - 7'h01);
        next_selected = !partial_on || (com_line >= window_lo && com_line <= window_hi);
        screen_row = com_line;
        if (tall_enable && in_tall(com_line, tall_first_row, tall_last_row))
        begin
            tall_offset = 7'(com_line - tall_first_row);
            screen_row = 7'(tall_first_row + (tall_offset >> 1));
        end
        else
        begin
            tall_offset = '0;
        end
        if (screen_row < fix_rows)
        begin
            next_mem_row = screen_row;
        end
        else
        begin
            // 7-bit sum wraps 128 back to row 0
            next_mem_row = 7'(scroll_start_row + screen_row - fix_rows);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            line_timer <= '0;
            com_line <= '0;
        end
        else if (line_timer == 8'(LINE_CYCLES - 1))
        begin
            line_timer <= '0;
            com_line <= (com_line == LRM_ROWS_LAST) ? 7'h00 : 7'(com_line + 7'h01);
        end
        else
        begin
            line_timer <= 8'(line_timer + 8'h01);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            line_out <= '0;
            com_index <= '0;
        end
        else
        begin
            com_index <= com_line;
            line_out.mem_row <= next_mem_row;
            line_out.selected <= next_selected;
            line_out.reverse <= reverse && next_selected;
        end
    end

    // ==========================================
    // drive decode
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            drive_out <= '0;
        end
        else
        begin
            drive_out.duty_div <= (duty_select == LRM_DUTY_16) ? LRM_DIV_16 : LRM_DIV_120;
            drive_out.bias_div <= (bias_select == LRM_BIAS_5) ? LRM_BIAS_DIV_5 : LRM_BIAS_DIV_11;
            drive_out.boost_mult <= (boost_factor == LRM_BOOST_2X) ? LRM_MULT_2 : LRM_MULT_6;
            drive_out.contrast <= contrast_level;
        end
    end

    // ==========================================
    // checks
    // line_out lags com_line by one edge, so every mapping check is |=>
    a_partial_window: assert property (@(posedge mclk) disable iff (!rst_n)
        partial_on && !centre_shift && com_line >= LRM_PART_ROWS |=> !line_out.selected)
        else $error("line outside partial window selected");

    a_partial_centre: assert property (@(posedge mclk) disable iff (!rst_n)
        partial_on && centre_shift && com_line >= LRM_CENTRE_OFFSET
        && com_line < 7'(LRM_CENTRE_OFFSET + LRM_PART_ROWS) |=> line_out.selected)
        else $error("centre window line not selected");

    a_unselected_off: assert property (@(posedge mclk) disable iff (!rst_n)
        partial_on && centre_shift && (com_line < LRM_CENTRE_OFFSET
        || com_line >= 7'(LRM_CENTRE_OFFSET + LRM_PART_ROWS))
        |=> !line_out.selected && !line_out.reverse)
        else $error("line outside centre window driven");

    a_full_select: assert property (@(posedge mclk) disable iff (!rst_n)
        !partial_on |=> line_out.selected)
        else $error("line dropped in normal drive");

    a_fixed_rows: assert property (@(posedge mclk) disable iff (!rst_n)
        !tall_enable && com_line < fix_rows |=> line_out.mem_row == $past(com_line))
        else $error("fixed row moved by scroll");

    a_scroll_first: assert property (@(posedge mclk) disable iff (!rst_n)
        !tall_enable && com_line == fix_rows |=> line_out.mem_row == $past(scroll_start_row))
        else $error("scroll start row misplaced");

    a_row_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        !tall_enable && fix_rows == 7'h00 && scroll_start_row == LRM_ROWS_LAST
        && com_line == 7'h01 |=> line_out.mem_row == 7'h00)
        else $error("memory row did not wrap");

    a_tall_off: assert property (@(posedge mclk) disable iff (!rst_n)
        !tall_enable && com_line >= fix_rows
        |=> line_out.mem_row == $past(7'(scroll_start_row + com_line - fix_rows)))
        else $error("scroll mapping wrong without tall");

    a_tall_start: assert property (@(posedge mclk) disable iff (!rst_n)
        tall_enable && fix_rows == 7'h00 && com_line == tall_first_row
        && tall_first_row <= tall_last_row
        |=> line_out.mem_row == $past(7'(scroll_start_row + tall_first_row)))
        else $error("tall area start misplaced");

    a_tall_end: assert property (@(posedge mclk) disable iff (!rst_n)
        tall_enable && fix_rows == 7'h00 && com_line == tall_last_row
        && tall_first_row <= tall_last_row
        |=> line_out.mem_row == $past(7'(scroll_start_row + tall_first_row
        + ((tall_last_row - tall_first_row) >> 1))))
        else $error("tall area end misplaced");

    // compares two successive line outputs; skipped where a write just moved a field
    a_tall_double: assert property (@(posedge mclk) disable iff (!rst_n)
        tall_enable && tall_first_row < tall_last_row && com_line == 7'(tall_first_row + 7'h01)
        && line_timer == 8'h00 && !$past(access && pwrite)
        |=> line_out.mem_row == $past(line_out.mem_row))
        else $error("tall row not repeated");

    a_rev_off: assert property (@(posedge mclk) disable iff (!rst_n)
        !reverse |=> !line_out.reverse)
        else $error("reverse without bit");

    a_rev_on: assert property (@(posedge mclk) disable iff (!rst_n)
        reverse && !partial_on |=> line_out.reverse)
        else $error("reverse bit not applied");

    a_duty_decode: assert property (@(posedge mclk) disable iff (!rst_n)
        duty_select == LRM_DUTY_16 |=> drive_out.duty_div == LRM_DIV_16)
        else $error("duty decode wrong");

    a_duty_normal: assert property (@(posedge mclk) disable iff (!rst_n)
        duty_select == LRM_DUTY_120 |=> drive_out.duty_div == LRM_DIV_120)
        else $error("normal duty decode wrong");

    a_bias_decode: assert property (@(posedge mclk) disable iff (!rst_n)
        bias_select == LRM_BIAS_5 |=> drive_out.bias_div == LRM_BIAS_DIV_5)
        else $error("bias decode wrong");

    a_bias_normal: assert property (@(posedge mclk) disable iff (!rst_n)
        bias_select == LRM_BIAS_11 |=> drive_out.bias_div == LRM_BIAS_DIV_11)
        else $error("normal bias decode wrong");

    a_boost_decode: assert property (@(posedge mclk) disable iff (!rst_n)
        boost_factor == LRM_BOOST_6X |=> drive_out.boost_mult == LRM_MULT_6)
        else $error("boost decode wrong");

    a_boost_two: assert property (@(posedge mclk) disable iff (!rst_n)
        boost_factor == LRM_BOOST_2X |=> drive_out.boost_mult == LRM_MULT_2)
        else $error("low boost decode wrong");

    a_contrast_pass: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> drive_out.contrast == $past(contrast_level))
        else $error("contrast not passed to drive");

    a_com_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> com_index == $past(com_line))
        else $error("common index lags wrongly");

    // zero-wait slave: ready never stretches over two cycles
    a_ready_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("ready held too long");

    c_partial: cover property (@(posedge mclk) partial_on && centre_shift && line_out.selected);
    c_tall: cover property (@(posedge mclk) tall_enable && in_tall(com_line, tall_first_row,
        tall_last_row));
    c_wrap: cover property (@(posedge mclk) scroll_start_row == LRM_ROWS_LAST);
    c_fixed: cover property (@(posedge mclk) fixed_area_select == 2'h3 && com_line == fix_rows);
endmodule

// ---- tb/lrm_panel_model.sv ----
// panel model: latches the mapping driven onto each common line
// assumes line_out and com_index settle within each line period
`timescale 1ns/1ps
module lrm_panel_model
(
    input wire logic mclk,
    input wire lrm_pkg::lrm_line_t line_out,
    input wire logic [6:0] com_index
);
    import lrm_pkg::*;
    lrm_line_t shown [0:127];
    // ==========================================
    // electrode latch
    // last write in a line period wins, so a one-cycle lag is harmless
    always_ff @(posedge mclk)
    begin
        shown[com_index] <= line_out;
    end
endmodule

// ---- tb/lrm_row_map_tb.sv ----
// self-checking bench for the row mapper, apb master plus panel model
// assumes zero-wait apb slave and a line scan of LINE_CYCLES clocks
`timescale 1ns/1ps
module lrm_row_map_tb;
    import lrm_pkg::*;
    localparam int LC = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    lrm_line_t line_out;
    logic [6:0] com_index;
    lrm_drive_t drive_out;
    int num_errors = 0;
    int comparisons = 0;
    always #5 mclk = ~mclk;
    lrm_row_map #(.LINE_CYCLES(LC)) u_lrm_row_map (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_out(line_out), .com_index(com_index),
        .drive_out(drive_out));
    lrm_panel_model u_lrm_panel_model (.mclk(mclk), .line_out(line_out), .com_index(com_index));
    // ==========================================
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        chk({31'h0, pready}, 32'h1, "pready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0, "write error");
    endtask
    // two whole frames so every common line has been rescanned
    task automatic settle();
        repeat (2 * 128 * LC + 8) @(posedge mclk);
    endtask
    task automatic line(input int i, input logic [6:0] m, input logic [1:0] sv, input string s);
        chk({23'h0, u_lrm_panel_model.shown[i]}, {23'h0, m, sv}, s);
    endtask
    task automatic st(input int i, input logic [1:0] sv, input string s);
        chk({30'h0, u_lrm_panel_model.shown[i].selected, u_lrm_panel_model.shown[i].reverse},
            {30'h0, sv}, s);
    endtask
    // ==========================================
    // scenarios
    task automatic t_fixed();
        wr(LRM_ADDR_SCROLL, 32'h0000_0300);
        settle();
        for (int i = 0; i < 24; i++) line(i, 7'(i), 2'b10, "icon");
        line(24, 7'h00, 2'b10, "first scroll");
        wr(LRM_ADDR_SCROLL, 32'h0000_0345);
        settle();
        for (int i = 0; i < 24; i++) line(i, 7'(i), 2'b10, "icon scrolled");
        line(24, 7'h45, 2'b10, "first scroll");
        wr(LRM_ADDR_SCROLL, 32'h0000_007F);
        settle();
        line(0, 7'h7F, 2'b10, "last row");
        line(1, 7'h00, 2'b10, "wrap");
        $display("test fixed and scroll done");
    endtask
    task automatic t_tall();
        wr(LRM_ADDR_SCROLL, 32'h0);
        wr(LRM_ADDR_TALL, 32'h0000_2708);
        wr(LRM_ADDR_CTRL, 32'h1);
        settle();
        line(7, 7'h07, 2'b10, "above tall");
        line(8, 7'h08, 2'b10, "tall start");
        line(9, 7'h08, 2'b10, "tall repeat");
        line(10, 7'h09, 2'b10, "tall advance");
        line(39, 7'h17, 2'b10, "tall end");
        line(40, 7'h28, 2'b10, "below tall");
        wr(LRM_ADDR_TALL, 32'h0000_2808);
        settle();
        line(40, 7'h18, 2'b10, "odd span end");
        wr(LRM_ADDR_SCROLL, 32'h5);
        settle();
        line(9, 7'h0D, 2'b10, "tall under scroll");
        wr(LRM_ADDR_CTRL, 32'h0);
        settle();
        line(9, 7'h0E, 2'b10, "tall off");
        $display("test double height done");
    endtask
    task automatic t_partial();
        wr(LRM_ADDR_SCROLL, 32'h0);
        wr(LRM_ADDR_CTRL, 32'h2);
        settle();
        line(5, 7'h05, 2'b11, "reversed");
        wr(LRM_ADDR_CTRL, 32'h6);
        settle();
        st(0, 2'b11, "top first");
        st(15, 2'b11, "top last");
        st(16, 2'b00, "top off");
        wr(LRM_ADDR_CTRL, 32'hE);
        settle();
        st(8'h33, 2'b00, "centre before");
        st(8'h34, 2'b11, "centre first");
        st(8'h43, 2'b11, "centre last");
        st(8'h44, 2'b00, "centre after");
        wr(LRM_ADDR_CTRL, 32'h0);
        $display("test reverse and partial done");
    endtask
    task automatic t_drive();
        logic [31:0] r;
        logic e;
        // boost decode ignores partial_on; both drive settings are checked with partial drive off
        wr(LRM_ADDR_DRIVE, 32'h0002_A20E);
        repeat (2) @(posedge mclk);
        chk({11'h0, drive_out}, {11'h0, 8'h78, 4'hB, 3'h6, 6'h2A}, "normal drive");
        wr(LRM_ADDR_DRIVE, 32'h0001_5061);
        repeat (2) @(posedge mclk);
        chk({11'h0, drive_out}, {11'h0, 8'h10, 4'h5, 3'h2, 6'h15}, "partial drive");
        apb(1'b0, LRM_ADDR_DRIVE, 32'h0, r, e);
        chk(r, 32'h0001_5061, "drive readback");
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        apb(1'b0, LRM_ADDR_STATUS, 32'h0, r, e);
        chk({r[31:7], 7'h00, e}, 33'h0, "status range");
        $display("test drive and bus done");
    endtask
    // ==========================================
    // run control
    task automatic final_report();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #400000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_fixed();
        t_tall();
        t_partial();
        t_drive();
        final_report();
    end
endmodule
